// file: hdt_fifo.sv
// line buffer fifo, flip-flop storage addressed by index
`timescale 1ns/10ps
`default_nettype none
module hdt_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n,   // synchronous reset, active low
    hdt_stream_if.snk wr,     // filling side
    hdt_stream_if.src rd      // draining side
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wp_reg;
    logic [PW-1:0] rp_reg;
    logic [PW:0] cnt_reg;
    wire push;
    wire pop;
    wire full;
    wire empty;

    // ==================================================
    // status and handshakes
    assign full = (cnt_reg == (PW+1)'(DEPTH));
    assign empty = (cnt_reg == '0);
    assign push = wr.valid & ~full;
    assign pop = rd.ready & ~empty;
    assign wr.ready = ~full;
    assign rd.valid = ~empty;
    assign rd.data = mem_reg[rp_reg];

    // pointer step with wrap
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    // storage and pointers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                mem_reg[wp_reg] <= wr.data;
                wp_reg <= step(wp_reg);
            end
            if (pop) begin
                rp_reg <= step(rp_reg);
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // hdt_fifo
`default_nettype wire

// file: hdt_partner.sv
// far-side model: modem answering request to send, and a line sink that can stall
`timescale 1ns/10ps
`default_nettype none
module hdt_partner (
    input wire logic ref_clk,         // system clock
    input wire logic rst_n,           // synchronous reset, active low
    input wire logic rts,             // request to send from the terminal
    input wire logic [7:0] cts_delay, // cts rises cts_delay+1 cycles after rts
    input wire logic stall,           // hold the line busy
    input wire logic line_valid,      // character offered
    input wire logic [7:0] line_data, // character offered
    output logic cts,                 // clear to send
    output logic line_ready,          // line takes a character
    output logic got,                 // character taken this cycle
    output logic [7:0] got_data       // character taken
);
    logic [7:0] wait_reg;
    // ==================================================
    // modem: answer rts after the set delay, withdraw one cycle after rts drops
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rts) begin
            wait_reg <= 8'h00;
            cts <= 1'b0;
        end else if (wait_reg >= cts_delay) begin
            cts <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 8'h01;
        end
    end
    // ==================================================
    // line sink: takes one character per cycle unless stalled
    assign line_ready = ~stall;
    assign got = line_valid & line_ready;
    assign got_data = line_data;
endmodule // hdt_partner
`default_nettype wire

// file: hdt_pkg.sv
// constants shared by the half-duplex transmit enable sequencer
`default_nettype none
package hdt_pkg;
    // ==================================================
    // timing
    localparam int CLK_NS = 10;                     // 100 MHz reference clock
    localparam int FRAME_NS = 16_000_000;           // one refresh frame, 16 ms
    localparam int FRAME_CYC = FRAME_NS / CLK_NS;   // clocks per frame
    localparam int MEM_CHARS = 1040;                // characters circulating per frame
    localparam int CHAR_CYC = FRAME_CYC / MEM_CHARS; // clocks per character slot
    // ==================================================
    // character codes
    localparam int CODE_W = 7;                      // data bits of a character
    localparam int LINE_W = CODE_W + 1;             // data plus parity bit
    localparam logic [6:0] CODE_STX = 7'h02;        // start of text
    localparam logic [6:0] CODE_ETX = 7'h03;        // end of text
    localparam logic [6:0] ADDR_DEFAULT = 7'h41;    // preset terminal address
    localparam int FIFO_DEPTH = 8;                  // line buffer words
    // ==================================================
    // odd parity bit over a character
    function automatic logic hdt_par(input logic [6:0] d);
        return ~^d;
    endfunction
endpackage
`default_nettype wire

// file: hdt_seq.sv
// transmit/receive enable sequencer with circulating refresh memory
`timescale 1ns/10ps
`default_nettype none
module hdt_seq
    import hdt_pkg::*;
#(
    parameter int DEPTH = MEM_CHARS,                  // refresh memory characters
    parameter int CHAR_DIV = CHAR_CYC,                // clocks per character slot
    parameter bit USE_CTS = 1'b1,                     // cts gates transmit steering
    parameter bit USE_RTS = 1'b1,                     // rts gates transmit steering
    parameter logic [6:0] TERMINAL_ADDR = ADDR_DEFAULT, // address character
    parameter int BUF_DEPTH = FIFO_DEPTH              // line buffer depth
) (
    input wire logic ref_clk,                      // system clock
    input wire logic rst_n,                        // synchronous reset, active low
    input wire logic [$clog2(DEPTH)-1:0] cursor_pos, // keyboard write position
    input wire logic key_strobe,                   // one-cycle key entry
    input wire logic [6:0] key_char,               // entered character
    input wire logic end_key,                      // end-of-message key pulse
    input wire logic send_key,                     // send key level
    input wire logic cts,                          // clear to send
    input wire logic rx_valid,                     // received character strobe
    input wire logic [7:0] rx_char,                // received character with parity
    input wire logic line_ready,                   // line takes a character
    output logic line_valid,                       // line character valid
    output logic [7:0] line_data,                  // line character with parity
    output logic rts,                              // request to send
    output logic t_steer,                          // transmit steering
    output logic r_steer,                          // receive steering
    output logic kbd_locked,                       // keyboard locked out
    output logic end_code_seen_pulse,              // end code entered entry register
    output logic shift_memory_flag,                // character extracted
    output logic timeout_pulse,                    // transmission ended
    output logic parity_error                      // received parity wrong
);
    localparam int AW = $clog2(DEPTH);
    localparam int DW = $clog2(CHAR_DIV);
    localparam logic [AW-1:0] PH3_SLOT = AW'(DEPTH / 2);
    localparam logic [AW-1:0] PH4_SLOT = AW'((3 * DEPTH) / 4);

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] v);
        return (v == AW'(DEPTH-1)) ? '0 : v + 1'b1;
    endfunction

    logic [6:0] mem_reg [DEPTH];
    logic [DW-1:0] div_reg;
    logic [AW-1:0] slot_reg;
    logic [AW-1:0] xptr_reg;
    logic [AW-1:0] rxp_reg;
    logic [6:0] s1_reg;
    logic [6:0] s2_reg;
    logic [6:0] s3_reg;
    logic stage_one_full;
    logic stage_two_full;
    logic stage_three_full;
    logic rts_reg;
    logic hdr_reg;
    logic pend_reg;
    logic xen_reg;
    logic endm_reg;
    logic pre_reg;
    logic tout_reg;
    logic lock_reg;
    logic r_steer_reg;
    logic t_steer_reg;
    logic seen_reg;
    logic shift_reg;
    logic to_reg;
    logic perr_reg;
    logic lv_reg;
    logic [7:0] ld_reg;

    hdt_stream_if #(.W(LINE_W)) fin ();
    hdt_stream_if #(.W(LINE_W)) fout ();

    hdt_fifo #(.W(LINE_W), .DEPTH(BUF_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr(fin),
        .rd(fout)
    );

    // ==================================================
    // frame timing
    wire char_en = (div_reg == DW'(CHAR_DIV-1));
    wire ph1 = char_en & (slot_reg == '0);
    wire ph3 = char_en & (slot_reg == PH3_SLOT);
    wire ph4 = char_en & (slot_reg == PH4_SLOT);
    wire [6:0] cur_char = mem_reg[slot_reg];

    // character slot divider and circulating position
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_reg <= '0;
            slot_reg <= '0;
        end else begin
            div_reg <= char_en ? '0 : div_reg + 1'b1;
            if (char_en) begin
                slot_reg <= wrap_inc(slot_reg);
            end
        end
    end

    // ==================================================
    // sequencer decodes
    wire cts_t = ~USE_CTS | cts;
    wire rts_t = ~USE_RTS | rts_reg;
    wire seen = char_en & (cur_char == CODE_ETX);
    wire start = seen & send_key & ~lock_reg & ~rts_reg & ~hdr_reg & ~tout_reg;
    wire hdr_load = ph1 & cts_t & rts_reg & ~hdr_reg;
    wire t_now = xen_reg & cts_t & rts_t;
    wire all_empty = ~stage_one_full & ~stage_two_full & ~stage_three_full
        & ~fout.valid & ~lv_reg;
    wire pre_set = ph3 & endm_reg & all_empty & t_steer_reg & ~tout_reg;
    wire to_fire = ph4 & tout_reg;
    wire ext = char_en & t_steer_reg & ~endm_reg & ~stage_one_full
        & (slot_reg == xptr_reg);

    // ==================================================
    // memory write selection
    wire rx_ok = rx_valid & r_steer_reg;
    wire rx_stx = rx_ok & (rx_char[6:0] == CODE_STX);
    wire rx_wr = rx_ok & ~rx_stx;
    wire end_wr = end_key & ~lock_reg & ~rx_wr;
    wire key_wr = key_strobe & ~end_key & ~lock_reg & ~rx_wr;
    wire [AW-1:0] wr_addr = rx_wr ? rxp_reg : cursor_pos;
    wire [6:0] wr_data = rx_wr ? rx_char[6:0] : (end_wr ? CODE_ETX : key_char);

    // refresh memory and receive pointer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            rxp_reg <= '0;
        end else begin
            if (rx_wr | end_wr | key_wr) begin
                mem_reg[wr_addr] <= wr_data;
            end
            if (rx_stx) begin
                rxp_reg <= '0;
            end else if (rx_wr) begin
                rxp_reg <= wrap_inc(rxp_reg);
            end
        end
    end

    // ==================================================
    // buffer stage moves
    assign fin.valid = stage_three_full;
    assign fin.data = {hdt_par(s3_reg), s3_reg};
    assign fout.ready = ~lv_reg | line_ready;
    wire mv3 = stage_three_full & fin.ready;
    wire mv2 = stage_two_full & (~stage_three_full | mv3);
    wire mv1 = stage_one_full & (~stage_two_full | mv2);

    // three buffer stages with their busy bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage_one_full <= 1'b0;
            stage_two_full <= 1'b0;
            stage_three_full <= 1'b0;
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            xptr_reg <= '0;
        end else begin
            if (ext) begin
                s1_reg <= cur_char;
                stage_one_full <= 1'b1;
                xptr_reg <= wrap_inc(xptr_reg);
            end else if (mv1) begin
                stage_one_full <= 1'b0;
            end
            if (hdr_load) begin
                s2_reg <= TERMINAL_ADDR;
                stage_two_full <= 1'b1;
                xptr_reg <= '0;
            end else if (start) begin
                stage_two_full <= 1'b0;
            end else if (mv1) begin
                s2_reg <= s1_reg;
                stage_two_full <= 1'b1;
            end else if (mv2) begin
                stage_two_full <= 1'b0;
            end
            if (hdr_load) begin
                s3_reg <= CODE_STX;
                stage_three_full <= 1'b1;
            end else if (start) begin
                stage_three_full <= 1'b0;
            end else if (mv2) begin
                s3_reg <= s2_reg;
                stage_three_full <= 1'b1;
            end else if (mv3) begin
                stage_three_full <= 1'b0;
            end
        end
    end

    // ==================================================
    // control flags
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rts_reg <= 1'b0;
            hdr_reg <= 1'b0;
            pend_reg <= 1'b0;
            xen_reg <= 1'b0;
            endm_reg <= 1'b0;
            pre_reg <= 1'b0;
            tout_reg <= 1'b0;
            r_steer_reg <= 1'b1;
        end else if (to_fire) begin
            rts_reg <= 1'b0;
            hdr_reg <= 1'b0;
            xen_reg <= 1'b0;
            endm_reg <= 1'b0;
            tout_reg <= 1'b0;
            r_steer_reg <= 1'b1;
        end else begin
            if (start) begin
                rts_reg <= 1'b1;
                r_steer_reg <= 1'b0;
            end
            if (hdr_load) begin
                hdr_reg <= 1'b1;
                pend_reg <= 1'b1;
            end else if (ph4) begin
                pend_reg <= 1'b0;
            end
            if (ph3 & pend_reg) begin
                xen_reg <= 1'b1;
            end
            if (ext & (cur_char == CODE_ETX)) begin
                endm_reg <= 1'b1;
            end
            if (pre_set) begin
                pre_reg <= 1'b1;
            end else if (ph4) begin
                pre_reg <= 1'b0;
            end
            if (ph4 & pre_reg) begin
                tout_reg <= 1'b1;
            end
        end
    end

    // output pulses, steering, lockout and line register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            t_steer_reg <= 1'b0;
            lock_reg <= 1'b0;
            seen_reg <= 1'b0;
            shift_reg <= 1'b0;
            to_reg <= 1'b0;
            perr_reg <= 1'b0;
            lv_reg <= 1'b0;
            ld_reg <= '0;
        end else begin
            t_steer_reg <= t_now & ~to_fire;
            if (start) begin
                lock_reg <= 1'b1;
            end else if (rx_wr & (rx_char[6:0] == CODE_ETX)) begin
                lock_reg <= 1'b0;
            end
            seen_reg <= seen;
            shift_reg <= ext;
            to_reg <= to_fire;
            perr_reg <= rx_ok & (hdt_par(rx_char[6:0]) != rx_char[7]);
            if (fout.ready) begin
                lv_reg <= fout.valid;
                ld_reg <= fout.data;
            end
        end
    end

    assign rts = rts_reg;
    assign t_steer = t_steer_reg;
    assign r_steer = r_steer_reg;
    assign kbd_locked = lock_reg;
    assign end_code_seen_pulse = seen_reg;
    assign shift_memory_flag = shift_reg;
    assign timeout_pulse = to_reg;
    assign parity_error = perr_reg;
    assign line_valid = lv_reg;
    assign line_data = ld_reg;

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_idle_rx_on: assert property (!rts_reg |-> r_steer_reg)
        else $error("receive steering low while idle");
    a_lock_keys: assert property (lock_reg && (key_strobe || end_key) && !rx_wr
        |=> mem_reg[$past(cursor_pos)] == $past(mem_reg[cursor_pos]))
        else $error("key written while locked");
    a_seen_pulse: assert property (seen |=> end_code_seen_pulse)
        else $error("end code seen pulse missing");
    a_start_rts: assert property (start |=> rts_reg && !r_steer_reg
        && !stage_two_full && !stage_three_full)
        else $error("send start effects missing");
    a_header_load: assert property (hdr_load |=> s3_reg == CODE_STX
        && s2_reg == TERMINAL_ADDR && pend_reg)
        else $error("header not loaded");
    a_xen_phase: assert property (pend_reg && ph3 && !to_fire |=> xen_reg)
        else $error("transmit enable not set");
    a_rts_held: assert property (rts_reg && !to_fire |=> rts_reg)
        else $error("rts dropped early");
    a_endm_arm: assert property (ext && cur_char == CODE_ETX |=> endm_reg)
        else $error("end flag not armed");
    a_tout_set: assert property (pre_reg && ph4 |=> tout_reg && !pre_reg)
        else $error("time-out not set");
    a_tout_end: assert property (to_fire |=> timeout_pulse && !rts_reg
        && r_steer_reg ##1 !t_steer_reg)
        else $error("time-out did not end transmit");
    a_shift_once: assert property (shift_memory_flag |=> !shift_memory_flag)
        else $error("shift flag longer than a cycle");
endmodule // hdt_seq
`default_nettype wire

// file: hdt_seq_tb.sv
// self-checking testbench for the transmit enable sequencer
`timescale 1ns/10ps
`default_nettype none
module hdt_seq_tb
    import hdt_pkg::*;
;
    localparam int DEP = 16; // short refresh memory
    localparam int DIV = 4;  // short character slot
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cursor_pos = 4'h0;
    logic key_strobe = 1'b0;
    logic [6:0] key_char = 7'h00;
    logic end_key = 1'b0;
    logic send_key = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_char = 8'h00;
    logic [7:0] cts_delay = 8'h00;
    logic stall = 1'b0;
    logic cts, line_ready, line_valid, rts, t_steer, r_steer, kbd_locked, got;
    logic end_code_seen_pulse, shift_memory_flag, timeout_pulse, parity_error;
    logic [7:0] line_data, got_data;
    logic opt_t_steer;
    logic tx_on = 1'b0;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int comparisons = 0;
    int smf_cnt = 0;
    int ecs_cnt = 0;
    // ==================================================
    // clock and instances
    always #5 ref_clk = ~ref_clk;
    hdt_seq #(.DEPTH(DEP), .CHAR_DIV(DIV)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cursor_pos(cursor_pos), .key_strobe(key_strobe),
        .key_char(key_char), .end_key(end_key), .send_key(send_key), .cts(cts),
        .rx_valid(rx_valid), .rx_char(rx_char), .line_ready(line_ready),
        .line_valid(line_valid), .line_data(line_data), .rts(rts), .t_steer(t_steer),
        .r_steer(r_steer), .kbd_locked(kbd_locked), .end_code_seen_pulse(end_code_seen_pulse),
        .shift_memory_flag(shift_memory_flag), .timeout_pulse(timeout_pulse),
        .parity_error(parity_error));
    hdt_partner i_far (
        .ref_clk(ref_clk), .rst_n(rst_n), .rts(rts), .cts_delay(cts_delay), .stall(stall),
        .line_valid(line_valid), .line_data(line_data), .cts(cts), .line_ready(line_ready),
        .got(got), .got_data(got_data));
    // option-wired copy: cts and rts left out of the steering gate
    hdt_seq #(.DEPTH(DEP), .CHAR_DIV(DIV), .USE_CTS(1'b0), .USE_RTS(1'b0)) i_opt (
        .ref_clk(ref_clk), .rst_n(rst_n), .cursor_pos(cursor_pos), .key_strobe(key_strobe),
        .key_char(key_char), .end_key(end_key), .send_key(send_key), .cts(cts),
        .rx_valid(rx_valid), .rx_char(rx_char), .line_ready(line_ready), .line_valid(),
        .line_data(), .rts(), .t_steer(opt_t_steer), .r_steer(), .kbd_locked(),
        .end_code_seen_pulse(), .shift_memory_flag(), .timeout_pulse(), .parity_error());
    // ==================================================
    // monitors: collect line characters, count pulses, watch rts hold
    always @(posedge ref_clk) begin
        if (got === 1'b1) got_q.push_back(got_data);
        if (shift_memory_flag === 1'b1) smf_cnt++;
        if (end_code_seen_pulse === 1'b1) ecs_cnt++;
        if (tx_on && rts !== 1'b1 && timeout_pulse !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: rts dropped before time-out", $time);
        end
    end
    // ==================================================
    // compare and access tasks
    task automatic chk_bit(input logic g, input logic e, input string m);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: %s got %b exp %b", $time, m, g, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic cmp_stream();
        chk_byte(8'(got_q.size()), 8'(exp_q.size()), "line count");
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk_byte(got_q[i], exp_q[i], "line char");
        end
    endtask
    // character with its odd parity bit on top
    function automatic logic [7:0] wp(input logic [6:0] c);
        return {~^c, c};
    endfunction
    // keyboard entry, or end key when e is set; called and left at a falling edge
    task automatic key_write(input logic [3:0] p, input logic [6:0] c, input logic e);
        cursor_pos = p;
        key_char = c;
        key_strobe = ~e;
        end_key = e;
        @(negedge ref_clk);
        key_strobe = 1'b0;
        end_key = 1'b0;
        @(negedge ref_clk);
    endtask
    // host character, then the parity flag one cycle later
    task automatic rx_send(input logic [7:0] b, input logic pe);
        rx_char = b;
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        chk_bit(parity_error, pe, "parity flag");
        @(negedge ref_clk);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return end_code_seen_pulse;
            1: return timeout_pulse;
            3: return opt_t_steer;
            default: return t_steer;
        endcase
    endfunction
    task automatic wait_for(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            $display("mismatch at %0t: wait %0d timed out", $time, w);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
    // ==================================================
    // test sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        chk_bit(r_steer, 1'b1, "reset receive steering");
        chk_bit(rts, 1'b0, "reset rts");
        rst_n = 1'b1;
        @(negedge ref_clk);
        $display("test reset done");
        // enquiry with slow modem and a stalled line
        for (int i = 0; i < 10; i++) key_write(i[3:0], 7'h30 + i[6:0], 1'b0);
        key_write(4'hA, 7'h00, 1'b1);
        cts_delay = 8'h40;
        stall = 1'b1;
        send_key = 1'b1;
        wait_for(0, 200);
        chk_bit(rts, 1'b1, "rts on send");
        chk_bit(r_steer, 1'b0, "receive off on send");
        chk_bit(kbd_locked, 1'b1, "keyboard locked");
        send_key = 1'b0;
        tx_on = 1'b1;
        key_write(4'h0, 7'h5A, 1'b0);
        rx_send(8'h00, 1'b0);
        chk_bit(t_steer, 1'b0, "no steering before cts");
        wait_for(3, 400);
        chk_bit(cts, 1'b0, "option steering ahead of cts");
        chk_bit(t_steer, 1'b0, "gated steering waits for cts");
        wait_for(2, 400);
        chk_bit(cts, 1'b1, "steering only with cts");
        repeat (300) @(negedge ref_clk);
        chk_bit(line_valid, 1'b1, "line held while stalled");
        chk_byte(8'(got_q.size()), 8'h00, "nothing taken while stalled");
        stall = 1'b0;
        wait_for(1, 3000);
        chk_bit(rts, 1'b0, "rts off at time-out");
        chk_bit(r_steer, 1'b1, "receive on at time-out");
        tx_on = 1'b0;
        @(negedge ref_clk);
        chk_bit(t_steer, 1'b0, "steering off after time-out");
        exp_q = {wp(CODE_STX), wp(ADDR_DEFAULT)};
        for (int i = 0; i < 10; i++) exp_q.push_back(wp(7'h30 + i[6:0]));
        exp_q.push_back(wp(CODE_ETX));
        cmp_stream();
        chk_byte(8'(smf_cnt), 8'h0B, "extraction pulses");
        $display("test enquiry done");
        // host response unlocks the keyboard
        rx_send(wp(CODE_STX), 1'b0);
        rx_send(wp(7'h41), 1'b0);
        rx_send(wp(CODE_ETX), 1'b0);
        @(negedge ref_clk);
        chk_bit(kbd_locked, 1'b0, "keyboard unlocked");
        rx_send(8'h55, 1'b1);
        ecs_cnt = 0;
        repeat (4 * DEP * DIV) @(negedge ref_clk);
        chk_byte(8'(ecs_cnt), 8'h08, "end code pulses in four frames");
        $display("test response done");
        // second enquiry from received text with a prompt modem
        cts_delay = 8'h00;
        got_q.delete();
        smf_cnt = 0;
        send_key = 1'b1;
        wait_for(0, 200);
        send_key = 1'b0;
        tx_on = 1'b1;
        wait_for(1, 3000);
        tx_on = 1'b0;
        @(negedge ref_clk);
        exp_q = {wp(CODE_STX), wp(ADDR_DEFAULT), wp(7'h41), wp(CODE_ETX)};
        cmp_stream();
        chk_byte(8'(smf_cnt), 8'h02, "extraction pulses");
        $display("test prompt session done");
        stop_test();
    end
endmodule // hdt_seq_tb
`default_nettype wire

// file: hdt_stream_if.sv
// valid/ready word stream between the sequencer and its line buffer
`timescale 1ns/10ps
`default_nettype none
interface hdt_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
